// *** common/ssx_alu_if.sv ***
// interface joining the execute top to its arithmetic unit
// assumes both ends sit on the same clock
`timescale 1ns/100ps
`default_nettype none
interface ssx_alu_if;
    import ssx_pkg::*;
    ssx_op_type op;
    logic [7:0] acc;
    logic [7:0] opnd;
    logic       carry_in;
    logic [7:0] result;
    logic       carry_out;
    logic       dcarry_out;
    logic       zero_out;
    modport ctrl (output op, acc, opnd, carry_in,
                  input result, carry_out, dcarry_out, zero_out);
    modport alu  (input op, acc, opnd, carry_in,
                  output result, carry_out, dcarry_out, zero_out);
endinterface : ssx_alu_if
`default_nettype wire

// *** common/ssx_pkg.sv ***
// package for the subtract/swap/xor/direction execute block
// assumes one core clock; operation codes come from the decoder
package ssx_pkg;

    // ---------------------------------------------------------------
    // operations
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        SSX_OP_NONE    = 3'h0,
        SSX_OP_SUB     = 3'h1,
        SSX_OP_SUBB    = 3'h2,
        SSX_OP_SWAP    = 3'h3,
        SSX_OP_XORLIT  = 3'h4,
        SSX_OP_XORREG  = 3'h5,
        SSX_OP_LOADDIR = 3'h6
    } ssx_op_type;

    // ---------------------------------------------------------------
    // sizes, selectors and reset values
    // ---------------------------------------------------------------
    localparam int DATA_W         = 8;
    localparam int ADDR_W         = 7;
    localparam int NIB_W          = 4;
    localparam logic [2:0] DIR_SEL_A   = 3'h5;
    localparam logic [2:0] DIR_SEL_B   = 3'h6;
    localparam logic [2:0] DIR_SEL_MIN = 3'h5;
    localparam logic [2:0] DIR_SEL_MAX = 3'h7;
    localparam logic [7:0] ACC_RST     = 8'h00;
    localparam logic [7:0] DIR_RST     = 8'hFF;
    localparam logic       FLAG_RST    = 1'b0;
    localparam logic       DEST_ACC    = 1'b0;

endpackage : ssx_pkg

// *** src/ssx_alu.sv ***
// combinational arithmetic unit of the execute block
// assumes operands are stable during the execute cycle
`timescale 1ns/100ps
`default_nettype none
module ssx_alu (
    ssx_alu_if.alu a
);
    import ssx_pkg::*;

    logic [8:0] diff;
    logic [4:0] ndiff;
    logic       borrow;

    // ---------------------------------------------------------------
    // result and flag computation
    // ---------------------------------------------------------------
    always_comb begin
        borrow = (a.op == SSX_OP_SUBB) ? ~a.carry_in : 1'b0;
        diff   = {1'b0, a.opnd} - {1'b0, a.acc} - {8'h00, borrow};
        ndiff  = {1'b0, a.opnd[3:0]} - {1'b0, a.acc[3:0]}
                 - {4'h0, borrow};
        case (a.op)
            SSX_OP_SUB, SSX_OP_SUBB: a.result = diff[7:0];
            SSX_OP_SWAP:   a.result = {a.opnd[3:0], a.opnd[7:4]};
            SSX_OP_XORLIT,
            SSX_OP_XORREG: a.result = a.acc ^ a.opnd;
            default:       a.result = a.acc;
        endcase
        a.carry_out  = ~diff[8];
        a.dcarry_out = ~ndiff[4];
        a.zero_out   = (a.result == 8'h00);
    end

endmodule : ssx_alu
`default_nettype wire

// *** src/ssx_exec.sv ***
// execute stage for subtract, swap, xor and direction-load operations
// assumes the decoder presents one operation per enabled cycle and
// supplies the file register value read at file_addr
// Notes on behaviour
// - subtract gives reg minus acc, flags updated
// - dest bit zero writes acc, one writes reg
// - borrow subtract also removes inverted carry
// - swap exchanges nibbles, flags untouched
// - xor literal into acc, zero flag only
// - direction load copies acc, selector five or six; seven loads nothing
// - selector five loads A, six loads B
// - xor register to destination, zero only
`timescale 1ns/100ps
`default_nettype none
module ssx_exec (
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic              ce,
    input  wire logic              op_valid,
    input  wire ssx_pkg::ssx_op_type op,
    input  wire logic [6:0]        file_addr,
    input  wire logic              dest_sel,
    input  wire logic [7:0]        file_rdata,
    input  wire logic [7:0]        literal,
    input  wire logic [2:0]        dir_sel,
    output logic [7:0]             acc,
    output logic                   carry_flag,
    output logic                   digit_carry_flag,
    output logic                   zero_flag,
    output logic                   file_we,
    output logic [6:0]             file_waddr,
    output logic [7:0]             file_wdata,
    output logic [7:0]             port_a_direction,
    output logic [7:0]             port_b_direction
);
    import ssx_pkg::*;

    ssx_alu_if au ();
    ssx_alu    u_alu (.a(au));

    logic go;
    logic reg_op;
    logic arith;
    logic zonly;
    logic dir_ok;

    // ---------------------------------------------------------------
    // operand routing
    // ---------------------------------------------------------------
    assign go       = ce & op_valid;
    assign au.op    = op;
    assign au.acc   = acc;
    assign au.opnd  = (op == SSX_OP_XORLIT) ? literal : file_rdata;
    assign au.carry_in = carry_flag;
    assign reg_op   = (op == SSX_OP_SUB) || (op == SSX_OP_SUBB) ||
                      (op == SSX_OP_SWAP) || (op == SSX_OP_XORREG);
    assign arith    = (op == SSX_OP_SUB) || (op == SSX_OP_SUBB);
    assign zonly    = (op == SSX_OP_XORLIT) || (op == SSX_OP_XORREG);
    assign dir_ok   = (dir_sel >= DIR_SEL_MIN) && (dir_sel <= DIR_SEL_MAX);

    // ---------------------------------------------------------------
    // accumulator
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            acc <= ACC_RST;
        end else if (go) begin
            if (op == SSX_OP_XORLIT) begin
                acc <= au.result;
            end else if (reg_op && dest_sel == DEST_ACC) begin
                acc <= au.result;
            end
        end
    end

    // ---------------------------------------------------------------
    // file register write-back
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            file_we    <= 1'b0;
            file_waddr <= 7'h00;
            file_wdata <= 8'h00;
        end else if (ce) begin
            file_we <= go && reg_op && dest_sel != DEST_ACC;
            if (go && reg_op) begin
                file_waddr <= file_addr;
                file_wdata <= au.result;
            end
        end
    end

    // ---------------------------------------------------------------
    // status flags
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            carry_flag       <= FLAG_RST;
            digit_carry_flag <= FLAG_RST;
            zero_flag        <= FLAG_RST;
        end else if (go) begin
            if (arith) begin
                carry_flag       <= au.carry_out;
                digit_carry_flag <= au.dcarry_out;
                zero_flag        <= au.zero_out;
            end else if (zonly) begin
                zero_flag <= au.zero_out;
            end
        end
    end

    // ---------------------------------------------------------------
    // direction registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            port_a_direction <= DIR_RST;
            port_b_direction <= DIR_RST;
        end else if (go && op == SSX_OP_LOADDIR && dir_ok) begin
            if (dir_sel == DIR_SEL_A) begin
                port_a_direction <= acc;
            end else if (dir_sel == DIR_SEL_B) begin
                port_b_direction <= acc;
            end
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    sequence sub_issue;
        go && op == SSX_OP_SUB;
    endsequence

    sub_carry_a: assert property (@(posedge clk) disable iff (!rstn)
        sub_issue |=> carry_flag == ($past(acc) <= $past(file_rdata)))
        else $error("carry wrong after subtract");

    dest_acc_a: assert property (@(posedge clk) disable iff (!rstn)
        go && reg_op && !dest_sel |=> !file_we)
        else $error("file written with accumulator destination");

    dest_reg_a: assert property (@(posedge clk) disable iff (!rstn)
        go && reg_op && dest_sel |=> file_we && acc == $past(acc))
        else $error("register destination write wrong");

    subb_res_a: assert property (@(posedge clk) disable iff (!rstn)
        go && op == SSX_OP_SUBB && !dest_sel |=>
        acc == 8'($past(file_rdata) - $past(acc) - {7'h00, !$past(carry_flag)}))
        else $error("borrow subtract result wrong");

    swap_flags_a: assert property (@(posedge clk) disable iff (!rstn)
        go && op == SSX_OP_SWAP |=> $stable(carry_flag) && $stable(zero_flag)
        && $stable(digit_carry_flag))
        else $error("swap changed flags");

    xorl_acc_a: assert property (@(posedge clk) disable iff (!rstn)
        go && op == SSX_OP_XORLIT |=> acc == ($past(acc) ^ $past(literal))
        && zero_flag == (acc == 8'h00) && $stable(carry_flag))
        else $error("xor literal wrong");

    dir_a_a: assert property (@(posedge clk) disable iff (!rstn)
        go && op == SSX_OP_LOADDIR && dir_sel == DIR_SEL_A |=>
        port_a_direction == $past(acc) && $stable(zero_flag))
        else $error("direction A not loaded");

    xorr_zero_a: assert property (@(posedge clk) disable iff (!rstn)
        go && op == SSX_OP_XORREG |=>
        zero_flag == (($past(acc) ^ $past(file_rdata)) == 8'h00)
        && $stable(carry_flag))
        else $error("xor register zero flag wrong");

    sequence subb_issue;
        go && op == SSX_OP_SUBB;
    endsequence

    sequence dir_issue;
        go && op == SSX_OP_LOADDIR;
    endsequence

    sequence swap_issue;
        go && op == SSX_OP_SWAP;
    endsequence

    sub_wdata_a: assert property (@(posedge clk) disable iff (!rstn)
        sub_issue ##0 dest_sel |=>
        file_wdata == 8'($past(file_rdata) - $past(acc)))
        else $error("subtract write-back data wrong");

    sub_dczero_a: assert property (@(posedge clk) disable iff (!rstn)
        sub_issue |=>
        digit_carry_flag ==
        (($past(acc) & 8'h0F) <= ($past(file_rdata) & 8'h0F))
        && zero_flag == ($past(acc) == $past(file_rdata)))
        else $error("subtract digit carry or zero wrong");

    subb_carry_a: assert property (@(posedge clk) disable iff (!rstn)
        subb_issue |=>
        carry_flag == (($past(file_rdata) > $past(acc)) ||
        ($past(file_rdata) == $past(acc) && $past(carry_flag))))
        else $error("borrow subtract carry wrong");

    swap_acc_a: assert property (@(posedge clk) disable iff (!rstn)
        swap_issue ##0 !dest_sel |=>
        acc == (($past(file_rdata) << 4) | ($past(file_rdata) >> 4)))
        else $error("swap result wrong");

    dir_b_a: assert property (@(posedge clk) disable iff (!rstn)
        dir_issue ##0 dir_sel == DIR_SEL_B |=>
        port_b_direction == $past(acc) && $stable(port_a_direction))
        else $error("direction B not loaded");

    dir_other_a: assert property (@(posedge clk) disable iff (!rstn)
        dir_issue ##0 (dir_sel != DIR_SEL_A && dir_sel != DIR_SEL_B) |=>
        $stable(port_a_direction) && $stable(port_b_direction))
        else $error("direction changed by other selector");

    dir_flags_a: assert property (@(posedge clk) disable iff (!rstn)
        dir_issue |=> $stable(carry_flag) && $stable(digit_carry_flag)
        && $stable(zero_flag) && $stable(acc))
        else $error("direction load changed flags");

    wb_pulse_a: assert property (@(posedge clk) disable iff (!rstn)
        file_we && ce && !(go && reg_op && dest_sel) |=> !file_we)
        else $error("write strobe longer than one cycle");

    freeze_a: assert property (@(posedge clk) disable iff (!rstn)
        !ce |=> $stable(acc) && $stable(file_we) && $stable(carry_flag)
        && $stable(port_a_direction) && $stable(port_b_direction))
        else $error("state changed while frozen");

endmodule : ssx_exec
`default_nettype wire

// *** tb/ssx_exec_test.sv ***
// testbench for the execute block: operation table, then hand tests
// assumes ssx_pkg and ssx_exec are compiled before this file
`timescale 1ns/100ps
`default_nettype none
module ssx_exec_test;
    import ssx_pkg::*;
    typedef struct {
        ssx_op_type op;
        logic [6:0] addr;
        logic       dest;
        logic [7:0] rd;
        logic [7:0] lit;
        logic [2:0] dsel;
        logic [7:0] acc;
        logic [3:0] flg;
        logic [7:0] wd;
        logic [7:0] pa;
        logic [7:0] pb;
    } ssx_row_type;
    logic        clk, rstn, ce, op_valid, dest_sel;
    ssx_op_type  op;
    logic [6:0]  file_addr, file_waddr;
    logic [7:0]  file_rdata, literal, acc, file_wdata, pa, pb;
    logic [2:0]  dir_sel;
    logic        c, dc, z, file_we;
    ssx_row_type rows[17];
    ssx_row_type r0;
    int          bad_count, tests_run;

    ssx_exec ssx_exec_inst (.clk(clk), .rstn(rstn), .ce(ce),
        .op_valid(op_valid), .op(op), .file_addr(file_addr),
        .dest_sel(dest_sel), .file_rdata(file_rdata), .literal(literal),
        .dir_sel(dir_sel), .acc(acc), .carry_flag(c),
        .digit_carry_flag(dc), .zero_flag(z), .file_we(file_we),
        .file_waddr(file_waddr), .file_wdata(file_wdata),
        .port_a_direction(pa), .port_b_direction(pb));

    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end

    task automatic check(input logic [7:0] seen, exp, input string msg);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h",
                     $time, msg, seen, exp);
        end
    endtask : check

    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done

    // inputs change at the falling edge, outputs read after the rise
    task automatic drive(input ssx_row_type r, input logic v, en);
        @(negedge clk);
        ce = en;
        op_valid = v;
        op = r.op;
        file_addr = r.addr;
        dest_sel = r.dest;
        file_rdata = r.rd;
        literal = r.lit;
        dir_sel = r.dsel;
        @(posedge clk);
        #1;
    endtask : drive

    task automatic check_row(input ssx_row_type r);
        check(acc, r.acc, "acc");
        check({4'h0, c, dc, z, file_we}, {4'h0, r.flg}, "flags");
        if (r.flg[0]) begin
            check(file_wdata, r.wd, "wdata");
            check({1'h0, file_waddr}, {1'h0, r.addr}, "waddr");
        end
        check(pa, r.pa, "dir a");
        check(pb, r.pb, "dir b");
    endtask : check_row

    initial begin
        #100000;
        bad_count++;
        test_done();
    end

    initial begin
        rstn = 1'h0;
        r0 = '{SSX_OP_NONE, 7'h00, 1'h0, 8'h00, 8'h00, 3'h0,
               8'h00, 4'h0, 8'h00, 8'hFF, 8'hFF};
        drive(r0, 1'h0, 1'h0);
        // flags column holds carry, digit carry, zero, write strobe
        rows = '{
    '{SSX_OP_XORLIT,7'h00,1'h0,8'h00,8'h03,3'h0,8'h03,4'h0,8'h00,8'hFF,8'hFF},
    '{SSX_OP_SUB,7'h7F,1'h1,8'h10,8'h00,3'h0,8'h03,4'h9,8'h0D,8'hFF,8'hFF},
    '{SSX_OP_SUB,7'h01,1'h0,8'h03,8'h00,3'h0,8'h00,4'hE,8'h00,8'hFF,8'hFF},
    '{SSX_OP_XORLIT,7'h00,1'h0,8'h00,8'h80,3'h0,8'h80,4'hC,8'h00,8'hFF,8'hFF},
    '{SSX_OP_SUBB,7'h02,1'h0,8'h90,8'h00,3'h0,8'h10,4'hC,8'h00,8'hFF,8'hFF},
    '{SSX_OP_SUB,7'h03,1'h0,8'h05,8'h00,3'h0,8'hF5,4'h4,8'h00,8'hFF,8'hFF},
    '{SSX_OP_SUBB,7'h00,1'h1,8'hF6,8'h00,3'h0,8'hF5,4'hF,8'h00,8'hFF,8'hFF},
    '{SSX_OP_SWAP,7'h04,1'h0,8'hA5,8'h00,3'h0,8'h5A,4'hE,8'h00,8'hFF,8'hFF},
    '{SSX_OP_SWAP,7'h2A,1'h1,8'h3C,8'h00,3'h0,8'h5A,4'hF,8'hC3,8'hFF,8'hFF},
    '{SSX_OP_XORREG,7'h15,1'h1,8'h5A,8'h00,3'h0,8'h5A,4'hF,8'h00,8'hFF,8'hFF},
    '{SSX_OP_XORREG,7'h05,1'h0,8'h0F,8'h00,3'h0,8'h55,4'hC,8'h00,8'hFF,8'hFF},
    '{SSX_OP_LOADDIR,7'h00,1'h0,8'h00,8'h00,3'h5,8'h55,4'hC,8'h00,8'h55,8'hFF},
    '{SSX_OP_XORLIT,7'h00,1'h0,8'h00,8'hFF,3'h0,8'hAA,4'hC,8'h00,8'h55,8'hFF},
    '{SSX_OP_LOADDIR,7'h00,1'h0,8'h00,8'h00,3'h6,8'hAA,4'hC,8'h00,8'h55,8'hAA},
    '{SSX_OP_LOADDIR,7'h00,1'h0,8'h00,8'h00,3'h7,8'hAA,4'hC,8'h00,8'h55,8'hAA},
    '{SSX_OP_LOADDIR,7'h00,1'h0,8'h00,8'h00,3'h4,8'hAA,4'hC,8'h00,8'h55,8'hAA},
    '{SSX_OP_XORLIT,7'h00,1'h0,8'h00,8'hAA,3'h0,8'h00,4'hE,8'h00,8'h55,8'hAA}};
        @(negedge clk);
        rstn = 1'h1;
        foreach (rows[i]) begin
            drive(rows[i], 1'h1, 1'h1);
            check_row(rows[i]);
        end
        $display("test table done");
        // a write-back subtract offered while frozen must leave no trace
        drive(rows[1], 1'h1, 1'h0);
        check_row(rows[16]);
        drive(rows[1], 1'h0, 1'h1);
        check_row(rows[16]);
        $display("test hold done");
        @(negedge clk);
        rstn = 1'h0;
        #1;
        check_row(r0);
        drive(r0, 1'h0, 1'h1);
        @(negedge clk);
        rstn = 1'h1;
        drive(rows[0], 1'h1, 1'h1);
        check_row(rows[0]);
        $display("test reset done");
        test_done();
    end
endmodule : ssx_exec_test
`default_nettype wire
